// ---- hdl/rtp_pkg.sv ----
// shared constants and types of the real-time trace port
// assumes one 100 MHz processor clock and an APB register slave
package rtp_pkg;

  // trigger cause vector, index equals the event's bit number
  localparam int RTP_EVT_W          = 11;
  localparam int RTP_EVT_IA_ONE     = 0;
  localparam int RTP_EVT_IA_TWO     = 1;
  localparam int RTP_EVT_IA_THREE   = 2;
  localparam int RTP_EVT_IA_FOUR    = 3;
  localparam int RTP_EVT_DA_ONE_RD  = 4;
  localparam int RTP_EVT_DA_ONE_WR  = 5;
  localparam int RTP_EVT_DA_TWO_RD  = 6;
  localparam int RTP_EVT_DA_TWO_WR  = 7;
  localparam int RTP_EVT_TRAP       = 8;
  localparam int RTP_EVT_EXCEPTION  = 9;
  localparam int RTP_EVT_UNCOND     = 10;
  localparam logic [10:0] RTP_UNCOND_MASK = 11'h400;

  // status widths
  localparam int RTP_EXEC_W  = 2;
  localparam int RTP_HALF_W  = 2;
  localparam int RTP_TRACE_W = 4;

  // apb register map
  localparam int          RTP_ADDR_W   = 12;
  localparam logic [11:0] RTP_CTRL_OFS = 12'h000;
  localparam logic [11:0] RTP_STAT_OFS = 12'h004;

  // control register fields
  localparam int         RTP_CTRL_INT_DBG_BIT = 0;
  localparam int         RTP_CTRL_EXT_DBG_BIT = 1;
  localparam int         RTP_CTRL_PASS_BIT    = 2;
  localparam logic [2:0] RTP_CTRL_RESET       = 3'h0;

  // status register fields
  localparam int RTP_STAT_CAUSE_LSB = 0;
  localparam int RTP_STAT_ACT_BIT   = 16;
  localparam int RTP_STAT_SUP_BIT   = 17;
  localparam int RTP_STAT_RET_BIT   = 18;

  // one trace cycle worth of broadcast data
  typedef struct packed {
    logic [1:0] first_exec;
    logic [1:0] second_exec;
    logic [3:0] trace;
  } rtp_pair_t;

  // collection sequencer
  typedef enum {
    RTP_IDLE,
    RTP_FIRST,
    RTP_SECOND
  } rtp_phase_t;

endpackage

// ---- hdl/rtp_trace_port.sv ----
// real-time trace port: trigger generation and two-cycle status packing
// assumes events and status arrive from core logic on CLK, the trigger
// return and suppress inputs from fabric logic on the same clock
//
// Operation
// - trigger output rises for any debug event while both debug modes are off
// - either debug mode blocks most events; trace collection itself stays enabled
// - eleven-bit cause vector, one bit per event, set bit means it caused trigger
// - instruction address matches one to four sit on cause bits 0 to 3
// - bits 4 to 10: data matches read/write, trap, exception, unconditional
// - trace cycle strobe appears once every two processor clocks
// - status sampled every cycle, each pair broadcast together in one trace cycle
// - first-cycle execution status comes from the first cycle of the pair
// - second-cycle execution status comes from the second cycle of the pair
// - four-bit reconstruct status follows the same two-cycle packing
// - returned trigger enables the extra reconstruct status, otherwise none
// - suppress stops collection after sending what was already collected
//
// The address map and the APB interface to the registers are this design's own decisions.
`timescale 1ns/1ps

module rtp_trace_port
  import rtp_pkg::*;
(
  input  wire logic                   CLK,
  input  wire logic                   RESET_N,
  input  wire logic                   PSEL,
  input  wire logic                   PENABLE,
  input  wire logic                   PWRITE,
  input  wire logic [RTP_ADDR_W-1:0]  PADDR,
  input  wire logic [31:0]            PWDATA,
  output logic      [31:0]            PRDATA,
  output logic                        PREADY,
  output logic                        PSLVERR,
  input  wire logic [RTP_EVT_W-1:0]   DEBUG_EVENTS,
  input  wire logic [RTP_EXEC_W-1:0]  EXEC_STATUS_IN,
  input  wire logic [RTP_HALF_W-1:0]  TRACE_STATUS_IN,
  input  wire logic                   TRIGGER_EVENT_RETURN,
  input  wire logic                   TRACE_SUPPRESS,
  output logic                        TRIGGER_EVENT_OUTPUT,
  output logic      [RTP_EVT_W-1:0]   TRIGGER_CAUSE_VECTOR,
  output logic                        TRACE_CYCLE_STROBE,
  output logic      [RTP_EXEC_W-1:0]  FIRST_CYCLE_EXEC_STATUS,
  output logic      [RTP_EXEC_W-1:0]  SECOND_CYCLE_EXEC_STATUS,
  output logic      [RTP_TRACE_W-1:0] TRACE_RECONSTRUCT_STATUS
);

  // register state
  logic [2:0]            ctrl_reg;
  logic [RTP_EVT_W-1:0]  last_cause_reg;
  logic [31:0]           prdata_reg;
  logic                  pready_reg;
  logic                  pslverr_reg;

  // sequencer and collection state
  rtp_phase_t            phase_reg;
  rtp_phase_t            phase_next;
  logic [RTP_EXEC_W-1:0] first_exec_reg;
  logic [RTP_HALF_W-1:0] first_trace_reg;
  logic [RTP_EVT_W-1:0]  cause_acc_reg;
  logic                  ret_seen_reg;

  // output flops
  logic                  trigger_reg;
  logic [RTP_EVT_W-1:0]  cause_reg;
  logic                  strobe_reg;
  rtp_pair_t             pair_reg;
  rtp_pair_t             pair_next;

  // combinational helpers
  logic                  internal_debug_mode;
  logic                  external_debug_mode;
  logic                  uncond_pass;
  logic                  debug_blocked;
  logic [RTP_EVT_W-1:0]  gated_evt;
  logic [RTP_EVT_W-1:0]  pair_cause;
  logic                  apb_setup;
  logic                  apb_commit;
  logic                  addr_ctrl;
  logic                  addr_stat;

  // control fields
  assign internal_debug_mode = ctrl_reg[RTP_CTRL_INT_DBG_BIT];
  assign external_debug_mode = ctrl_reg[RTP_CTRL_EXT_DBG_BIT];
  assign uncond_pass         = ctrl_reg[RTP_CTRL_PASS_BIT];

  // event gating: any debug mode blocks all but, optionally, unconditional
  assign debug_blocked = internal_debug_mode | external_debug_mode;
  always_comb
  begin
    if (!debug_blocked)
    begin
      gated_evt = DEBUG_EVENTS;
    end
    else if (uncond_pass)
    begin
      gated_evt = DEBUG_EVENTS & RTP_UNCOND_MASK;
    end
    else
    begin
      gated_evt = '0;
    end
  end

  // cause bits keep their index, so the vector maps straight through
  assign pair_cause = cause_acc_reg | gated_evt;

  // apb decode, zero wait states: pready follows setup by one cycle
  assign apb_setup  = PSEL & ~PENABLE & ~pready_reg;
  assign apb_commit = PSEL & PENABLE & pready_reg;
  assign addr_ctrl  = (PADDR == RTP_CTRL_OFS);
  assign addr_stat  = (PADDR == RTP_STAT_OFS);

  // ready and error answer, one cycle wide in the access phase
  always_ff @(posedge CLK)
  begin
    if (!RESET_N)
    begin
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
    end
    else
    begin
      pready_reg  <= apb_setup;
      pslverr_reg <= apb_setup & ~addr_ctrl & ~addr_stat;
    end
  end

  // read data is latched at setup so it stands through the access phase
  always_ff @(posedge CLK)
  begin
    if (!RESET_N)
    begin
      prdata_reg <= '0;
    end
    else if (apb_setup && !PWRITE)
    begin
      prdata_reg <= '0;
      if (addr_ctrl)
      begin
        prdata_reg[2:0] <= ctrl_reg;
      end
      else if (addr_stat)
      begin
        prdata_reg[RTP_STAT_CAUSE_LSB +: RTP_EVT_W] <= last_cause_reg;
        prdata_reg[RTP_STAT_ACT_BIT]                <= (phase_reg != RTP_IDLE);
        prdata_reg[RTP_STAT_SUP_BIT]                <= TRACE_SUPPRESS;
        prdata_reg[RTP_STAT_RET_BIT]                <= ret_seen_reg;
      end
    end
  end

  // control writes take effect only at the completing edge
  always_ff @(posedge CLK)
  begin
    if (!RESET_N)
    begin
      ctrl_reg <= RTP_CTRL_RESET;
    end
    else if (apb_commit && PWRITE && addr_ctrl)
    begin
      ctrl_reg <= PWDATA[2:0];
    end
  end

  // last nonzero cause kept for software; read-only, so no clear race
  always_ff @(posedge CLK)
  begin
    if (!RESET_N)
    begin
      last_cause_reg <= '0;
    end
    else if (phase_reg == RTP_SECOND && pair_cause != '0)
    begin
      last_cause_reg <= pair_cause;
    end
  end

  // sequencer: a started pair always finishes, so collected data drains
  always_comb
  begin
    phase_next = phase_reg;
    case (phase_reg)
      RTP_IDLE:
      begin
        if (!TRACE_SUPPRESS)
        begin
          phase_next = RTP_FIRST;
        end
      end
      RTP_FIRST:
      begin
        phase_next = RTP_SECOND;
      end
      RTP_SECOND:
      begin
        phase_next = TRACE_SUPPRESS ? RTP_IDLE : RTP_FIRST;
      end
      default:
      begin
        phase_next = RTP_IDLE;
      end
    endcase
  end

  // sequencer state; trace is always on unless the fabric suppresses it
  always_ff @(posedge CLK)
  begin
    if (!RESET_N)
    begin
      phase_reg <= RTP_IDLE;
    end
    else
    begin
      phase_reg <= phase_next;
    end
  end

  // first half of the pair is held until the second half arrives
  always_ff @(posedge CLK)
  begin
    if (!RESET_N)
    begin
      first_exec_reg  <= '0;
      first_trace_reg <= '0;
      cause_acc_reg   <= '0;
    end
    else if (phase_reg == RTP_FIRST)
    begin
      first_exec_reg  <= EXEC_STATUS_IN;
      first_trace_reg <= TRACE_STATUS_IN;
      cause_acc_reg   <= gated_evt;
    end
    else
    begin
      cause_acc_reg   <= '0;
    end
  end

  // returned trigger is caught in the trace cycle it qualifies
  always_ff @(posedge CLK)
  begin
    if (!RESET_N)
    begin
      ret_seen_reg <= 1'b0;
    end
    else if (strobe_reg)
    begin
      ret_seen_reg <= TRIGGER_EVENT_RETURN;
    end
  end

  // packing of the pair; reconstruct status needs a returned trigger
  always_comb
  begin
    pair_next.first_exec  = first_exec_reg;
    pair_next.second_exec = EXEC_STATUS_IN;
    if (ret_seen_reg)
    begin
      pair_next.trace = {TRACE_STATUS_IN, first_trace_reg};
    end
    else
    begin
      pair_next.trace = '0;
    end
  end

  // broadcast flops: strobe, trigger and cause last one processor clock
  always_ff @(posedge CLK)
  begin
    if (!RESET_N)
    begin
      strobe_reg  <= 1'b0;
      trigger_reg <= 1'b0;
      cause_reg   <= '0;
    end
    else if (phase_reg == RTP_SECOND)
    begin
      strobe_reg  <= 1'b1;
      trigger_reg <= |pair_cause;
      cause_reg   <= pair_cause;
    end
    else
    begin
      strobe_reg  <= 1'b0;
      trigger_reg <= 1'b0;
      cause_reg   <= '0;
    end
  end

  // status buses hold between trace cycles to keep pin switching low
  always_ff @(posedge CLK)
  begin
    if (!RESET_N)
    begin
      pair_reg <= '0;
    end
    else if (phase_reg == RTP_SECOND)
    begin
      pair_reg <= pair_next;
    end
  end

  // ports straight from flops
  assign PRDATA                   = prdata_reg;
  assign PREADY                   = pready_reg;
  assign PSLVERR                  = pslverr_reg;
  assign TRIGGER_EVENT_OUTPUT     = trigger_reg;
  assign TRIGGER_CAUSE_VECTOR     = cause_reg;
  assign TRACE_CYCLE_STROBE       = strobe_reg;
  assign FIRST_CYCLE_EXEC_STATUS  = pair_reg.first_exec;
  assign SECOND_CYCLE_EXEC_STATUS = pair_reg.second_exec;
  assign TRACE_RECONSTRUCT_STATUS = pair_reg.trace;

  // checks on the driven outputs
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!RESET_N);

  AST_STROBE_SPACING:
    assert property (TRACE_CYCLE_STROBE |=> !TRACE_CYCLE_STROBE)
    else $error("trace strobe on two adjacent cycles");

  AST_STROBE_AFTER_PAIR:
    assert property ((phase_reg == RTP_FIRST) |=> ##1 TRACE_CYCLE_STROBE)
    else $error("no trace strobe after a collected pair");

  AST_TRIGGER_CAUSE:
    assert property (TRIGGER_EVENT_OUTPUT == (|TRIGGER_CAUSE_VECTOR))
    else $error("trigger output disagrees with cause vector");

  AST_TRIGGER_IN_CYCLE:
    assert property (TRIGGER_EVENT_OUTPUT |-> TRACE_CYCLE_STROBE)
    else $error("trigger outside a trace cycle");

  AST_DEBUG_BLOCK:
    assert property ((phase_reg == RTP_SECOND && debug_blocked && !uncond_pass
                      && $past(debug_blocked) && !$past(uncond_pass))
                     |=> !TRIGGER_EVENT_OUTPUT)
    else $error("trigger raised while a debug mode blocks it");

  AST_CAUSE_MAP:
    assert property ((phase_reg == RTP_SECOND && !debug_blocked
                      && !$past(debug_blocked) && $past(phase_reg) == RTP_FIRST)
                     |=> TRIGGER_CAUSE_VECTOR
                         == ($past(DEBUG_EVENTS) | $past(DEBUG_EVENTS, 2)))
    else $error("cause vector does not match the events of the pair");

  AST_SECOND_EXEC:
    assert property ((phase_reg == RTP_SECOND)
                     |=> SECOND_CYCLE_EXEC_STATUS == $past(EXEC_STATUS_IN))
    else $error("second-cycle status not from the second cycle");

  AST_FIRST_EXEC:
    assert property ((phase_reg == RTP_FIRST)
                     |=> ##1 FIRST_CYCLE_EXEC_STATUS == $past(EXEC_STATUS_IN, 2))
    else $error("first-cycle status not from the first cycle");

  AST_RECON_GATE:
    assert property ((phase_reg == RTP_SECOND && !ret_seen_reg)
                     |=> TRACE_RECONSTRUCT_STATUS == '0)
    else $error("reconstruct status without a returned trigger");

  AST_SUPPRESS_STOP:
    assert property ((TRACE_SUPPRESS && phase_reg != RTP_FIRST)
                     |=> ##1 !TRACE_CYCLE_STROBE ##1 !TRACE_CYCLE_STROBE)
    else $error("trace broadcast continued under suppress");

  AST_SUPPRESS_DRAIN:
    assert property ((TRACE_SUPPRESS && phase_reg == RTP_SECOND)
                     |=> TRACE_CYCLE_STROBE)
    else $error("collected pair dropped on suppress");

  AST_RESET_QUIET:
    assert property (disable iff (1'b0) !RESET_N
                     |=> !TRIGGER_EVENT_OUTPUT && !TRACE_CYCLE_STROBE
                         && TRIGGER_CAUSE_VECTOR == '0)
    else $error("trigger or strobe active after a reset cycle");

endmodule

// ---- testbench/rtp_fabric_qual.sv ----
// fabric model: qualifies the trace trigger with a cause mask, wraps it back
// assumes trigger and cause are registered outputs of the trace port
`timescale 1ns/1ps

module rtp_fabric_qual
  import rtp_pkg::*;
(
  input  wire logic                 TRIGGER_EVENT_OUTPUT,
  input  wire logic [RTP_EVT_W-1:0] TRIGGER_CAUSE_VECTOR,
  input  wire logic [RTP_EVT_W-1:0] QUALIFY_MASK,
  output logic                      TRIGGER_EVENT_RETURN
);
  // combinational, so the return lands inside the same trace cycle
  // a trace collector would align its capture to this same wire
  assign TRIGGER_EVENT_RETURN = TRIGGER_EVENT_OUTPUT
                                & (|(TRIGGER_CAUSE_VECTOR & QUALIFY_MASK));
endmodule

// ---- testbench/rtp_trace_port_bench.sv ----
// self-checking bench of the trace port with a fabric qualifier model
// assumes apb answers within sixteen access cycles and a steady two-clock trace cycle
`timescale 1ns/1ps

module rtp_trace_port_bench
  import rtp_pkg::*;
;
  logic        clk = 1'b0;
  logic        reset_n = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [10:0] events = 11'h000;
  logic [1:0]  exec_in = 2'h0;
  logic [1:0]  trace_in = 2'h0;
  logic        suppress = 1'b0;
  logic [10:0] qual_mask = 11'h7FF;
  logic        trig_ret;
  logic        trig_out;
  logic [10:0] cause;
  logic        strobe;
  logic [1:0]  first_ex;
  logic [1:0]  second_ex;
  logic [3:0]  recon;
  logic [1:0]  held_ex;
  logic [1:0]  held_tr;
  int          miscompares = 0;
  int          cmp_count = 0;
  int          cycles = 0;

  // 100 MHz processor clock
  always #5 clk = ~clk;

  rtp_trace_port DUT (
    .CLK                      (clk),
    .RESET_N                  (reset_n),
    .PSEL                     (psel),
    .PENABLE                  (penable),
    .PWRITE                   (pwrite),
    .PADDR                    (paddr),
    .PWDATA                   (pwdata),
    .PRDATA                   (prdata),
    .PREADY                   (pready),
    .PSLVERR                  (pslverr),
    .DEBUG_EVENTS             (events),
    .EXEC_STATUS_IN           (exec_in),
    .TRACE_STATUS_IN          (trace_in),
    .TRIGGER_EVENT_RETURN     (trig_ret),
    .TRACE_SUPPRESS           (suppress),
    .TRIGGER_EVENT_OUTPUT     (trig_out),
    .TRIGGER_CAUSE_VECTOR     (cause),
    .TRACE_CYCLE_STROBE       (strobe),
    .FIRST_CYCLE_EXEC_STATUS  (first_ex),
    .SECOND_CYCLE_EXEC_STATUS (second_ex),
    .TRACE_RECONSTRUCT_STATUS (recon)
  );

  rtp_fabric_qual FABRIC (
    .TRIGGER_EVENT_OUTPUT (trig_out),
    .TRIGGER_CAUSE_VECTOR (cause),
    .QUALIFY_MASK         (qual_mask),
    .TRIGGER_EVENT_RETURN (trig_ret)
  );

  // one comparison, counted
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // single exit of the run
  task automatic report_and_stop;
    $display("compares %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // hang guard, a few thousand cycles is far beyond the whole sequence
  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 4000)
    begin
      miscompares++;
      report_and_stop();
    end
  end

  // apb transfer; request held until pready is sampled high at a rising edge
  task automatic apb(input logic wr, input logic [11:0] addr, input logic [31:0] wd,
                     output logic [31:0] rd, output logic err);
    int   n;
    logic rdy;
    n = 0;
    rdy = 1'b0;
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= addr;
    pwdata  <= wd;
    @(posedge clk);
    penable <= 1'b1;
    do
    begin
      @(posedge clk);
      rdy = pready;
      n++;
    end
    while (rdy !== 1'b1 && n < 16);
    check(rdy, 1'b1);
    rd  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  // land on the negedge of a strobe cycle
  task automatic sync_strobe;
    int n;
    n = 0;
    @(negedge clk);
    while (strobe !== 1'b1 && n < 8)
    begin
      @(negedge clk);
      n++;
    end
  endtask

  // one pair {exec,trace} a then b, events ea then eb; status is left at b
  task automatic pair(input logic [3:0] a, input logic [3:0] b, input logic [10:0] ea,
                      input logic [10:0] eb, input logic [10:0] exp_cause);
    sync_strobe();
    @(posedge clk);
    @(posedge clk);
    {exec_in, trace_in} <= a;
    events <= ea;
    @(posedge clk);
    {exec_in, trace_in} <= b;
    events <= eb;
    @(posedge clk);
    events <= 11'h000;
    @(negedge clk);
    held_ex = b[3:2];
    held_tr = b[1:0];
    check(strobe, 1'b1);
    check(trig_out, |exp_cause);
    check(cause, exp_cause);
    check(first_ex, a[3:2]);
    check(second_ex, b[3:2]);
    check(recon, 4'h0);
  endtask

  // next trace cycle after a pair: trace input flips in its second cycle
  task automatic hold_check(input logic ret);
    @(posedge clk);
    trace_in <= ~held_tr;
    @(negedge clk);
    check(strobe, 1'b0);
    @(negedge clk);
    check(strobe, 1'b1);
    check(trig_out, 1'b0);
    check(first_ex, held_ex);
    check(second_ex, held_ex);
    check(recon, ret ? {~held_tr, held_tr} : 4'h0);
  endtask

  // register reset value, read-only write, unmapped access
  task automatic t_regs;
    logic [31:0] rd;
    logic        err;
    apb(1'b0, RTP_CTRL_OFS, 32'h0, rd, err);
    check(rd, 32'h0);
    apb(1'b1, RTP_STAT_OFS, 32'hFFFFFFFF, rd, err);
    check(err, 1'b0);
    apb(1'b0, RTP_STAT_OFS, 32'h0, rd, err);
    check(rd, 32'h1 << RTP_STAT_ACT_BIT);
    apb(1'b0, 12'h008, 32'h0, rd, err);
    check(err, 1'b1);
    check(rd, 32'h0);
    $display("test regs done");
  endtask

  // strobe count over twenty clocks, never on adjacent cycles
  task automatic t_period;
    int   n;
    int   adj;
    logic prev;
    n = 0;
    adj = 0;
    prev = 1'b0;
    sync_strobe();
    repeat (20)
    begin
      @(negedge clk);
      if (strobe === 1'b1)
      begin
        n++;
        if (prev)
          adj++;
      end
      prev = strobe;
    end
    check(n, 10);
    check(adj, 0);
    $display("test period done");
  endtask

  // every cause bit, each pair mixing two events
  task automatic t_cause;
    logic [10:0] ea;
    logic [10:0] eb;
    for (int i = 0; i < 11; i++)
    begin
      ea = 11'h001 << i;
      eb = 11'h001 << ((i + 3) % 11);
      pair(4'(i * 5), 4'(i * 3 + 2), ea, eb, ea | eb);
    end
    $display("test cause done");
  endtask

  // debug modes block events; pass bit lets only the unconditional one through
  task automatic t_modes;
    logic [31:0] rd;
    logic        err;
    apb(1'b1, RTP_CTRL_OFS, 32'h1, rd, err);
    apb(1'b0, RTP_CTRL_OFS, 32'h0, rd, err);
    check(rd, 32'h1);
    pair(4'h6, 4'h9, 11'h7FF, 11'h7FF, 11'h000);
    apb(1'b1, RTP_CTRL_OFS, 32'h2, rd, err);
    pair(4'h6, 4'h9, 11'h001, 11'h400, 11'h000);
    apb(1'b1, RTP_CTRL_OFS, 32'h5, rd, err);
    pair(4'h3, 4'hC, 11'h0FF, 11'h400, 11'h400);
    apb(1'b1, RTP_CTRL_OFS, 32'h0, rd, err);
    $display("test modes done");
  endtask

  // qualified return adds reconstruct status to the following trace cycle
  task automatic t_return;
    qual_mask <= 11'h001;
    pair(4'h1, 4'h6, 11'h001, 11'h000, 11'h001);
    hold_check(1'b1);
    pair(4'h2, 4'hB, 11'h002, 11'h000, 11'h002);
    hold_check(1'b0);
    qual_mask <= 11'h7FF;
    $display("test return done");
  endtask

  // suppress in the second half: the open pair still goes out, then silence
  task automatic t_suppress;
    int n;
    n = 0;
    sync_strobe();
    @(posedge clk);
    suppress <= 1'b1;
    repeat (12)
    begin
      @(negedge clk);
      n += int'(strobe === 1'b1);
    end
    check(n, 1);
    @(posedge clk);
    suppress <= 1'b0;
    n = 0;
    repeat (12)
    begin
      @(negedge clk);
      n += int'(strobe === 1'b1);
    end
    check(n > 0, 1'b1);
    $display("test suppress done");
  endtask

  // reset in mid-run with all events active
  task automatic t_rst;
    @(posedge clk);
    events  <= 11'h7FF;
    reset_n <= 1'b0;
    @(posedge clk);
    @(negedge clk);
    check(strobe, 1'b0);
    check(trig_out, 1'b0);
    check(cause, 11'h000);
    @(posedge clk);
    reset_n <= 1'b1;
    events  <= 11'h000;
    t_period();
    $display("test reset done");
  endtask

  // reset for three clocks, then the scenarios
  initial
  begin
    repeat (2) @(posedge clk);
    @(negedge clk);
    check(strobe, 1'b0);
    check(trig_out, 1'b0);
    check(cause, 11'h000);
    @(posedge clk);
    reset_n <= 1'b1;
    t_regs();
    t_period();
    t_cause();
    t_modes();
    t_return();
    t_suppress();
    t_rst();
    report_and_stop();
  end
endmodule
